// file: src/mcmc_pkg.sv
// Purpose: Constants and types for the codec mode and control block
// Assumes: Register addresses are five bits wide, data eight bits
// Notes:   Frame format bit positions are fixed here; other field placement is fixed in mcmc_top
package mcmc_pkg;

  // Register addresses
  localparam logic [4:0] ADDR_FRAME  = 5'h00;
  localparam logic [4:0] ADDR_DEEMPH = 5'h08;
  localparam logic [4:0] ADDR_RAMP   = 5'h09;
  localparam logic [4:0] ADDR_ZDET   = 5'h0A;
  localparam logic [4:0] ADDR_VOL4L  = 5'h0B;
  localparam logic [4:0] ADDR_VOL4R  = 5'h0C;
  localparam logic [4:0] ADDR_STATUS = 5'h0D;

  // Bit positions in the frame format register
  localparam int FRM_TDM_BIT  = 7;
  localparam int FRM_SRC_BIT  = 6;
  localparam int FRM_DFS_BIT  = 5;
  localparam int FRM_MUTE_BIT = 0;

  // Volume transition times in sample periods
  localparam int RAMP_SLOW_FS = 7424;
  localparam int RAMP_MID_FS  = 1024;
  localparam int RAMP_FAST_FS = 256;
  localparam int VOL_LEVELS   = 256;
  localparam logic [4:0] STEP_SLOW = 5'(RAMP_SLOW_FS / VOL_LEVELS);
  localparam logic [4:0] STEP_MID  = 5'(RAMP_MID_FS / VOL_LEVELS);
  localparam logic [4:0] STEP_FAST = 5'(RAMP_FAST_FS / VOL_LEVELS);
  localparam logic [1:0] RAMP_SLOW = 2'h0;
  localparam logic [1:0] RAMP_MID  = 2'h1;
  localparam logic [1:0] RAMP_FAST = 2'h2;

  localparam logic [7:0] VOL_FULL = 8'hFF;
  localparam logic [7:0] VOL_MUTE = 8'h00;

  // Zero detection
  localparam logic [3:0] ZDM_ALL  = 4'h0;
  localparam logic [3:0] ZDM_OFF  = 4'h7;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_LO  = 8'h0F;
  localparam logic [7:0] MASK_HI  = 8'hF0;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam int ZERO_FRAMES_DEF  = 8192;

  // Control port
  localparam logic [4:0] TW_LEN    = 5'h10;
  localparam logic [4:0] I2C_BASE  = 5'h04; // Arbitrary value
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef struct packed {
    logic       tdm;
    logic       src;
    logic       double_speed_select;
    logic       soft_mute_pin;
    logic [1:0] deemph;
    logic [1:0] ramp;
    logic [3:0] zdm;
    logic [7:0] vol_l;
    logic [7:0] vol_r;
  } mcmc_regs_t;

  localparam mcmc_regs_t REGS_RST = '0;

  typedef struct packed {
    logic       src;
    logic       bus_sel;
    logic       soft_mute_pin;
    logic       double_speed_select;
    logic       zde;
    logic       power_down_n;
    logic       cms;
    logic       tdm;
    logic [1:0] cad;
    logic       csn;
    logic       cclk;
    logic       cdti;
    logic       scl;
    logic       sda;
  } mcmc_pins_t;

  localparam mcmc_pins_t PINS_RST = '0;

  typedef enum logic [6:0] {
    I2C_IDLE = 7'h01,
    I2C_DEV  = 7'h02,
    I2C_DACK = 7'h04,
    I2C_REG  = 7'h08,
    I2C_WDAT = 7'h10,
    I2C_ACK  = 7'h20,
    I2C_RDAT = 7'h40
  } mcmc_i2c_t;

endpackage : mcmc_pkg

// file: src/mcmc_top.sv
// Purpose: Mode and control logic of a multichannel codec digital side
// Assumes: i_clk_sys is the master clock; i_bit_clk runs the audio link
// Notes:   Control port pins are sampled on the master clock
//
// Summary of operation
// RULE_01: Serial output carries converter data when source select low, aux input when high.
// RULE_02: Host keeps source select low while multiplexed frame format is on.
// RULE_03: Control port is three-wire serial when bus select low, I2C slave when high.
// RULE_04: Soft mute pin high ramps outputs down; low ramps them back.
// RULE_05: Double speed select low gives normal speed, high gives double speed.
// RULE_06: Zero enable low: mode 7 under pins, register mode under serial control.
// RULE_07: Zero enable high: mode 0, first flag is AND of all eight channels.
// RULE_08: Power-down low holds the block down and resets every register.
// RULE_09: Host pulses power-down after changing control mode or chip address.
// RULE_10: Two-bit ramp field at 09H picks 7424, 1024 or 256 sample periods.
// RULE_11: Pair four left and right volumes live at 0BH and 0CH.
// RULE_12: Each output has 256 volume levels in 0.5 dB steps.
// RULE_13: Frame format bit at 00H selects multiplexed format.
// RULE_14: Two-bit de-emphasis field for pair four at 08H.
// RULE_15: Four-bit zero detection mode field at 0AH picks flag groups.
// RULE_16: Host supplies master clock at a supported multiple of sample rate.
// RULE_17: Zero flag rises only after 8192 consecutive all-zero frames.
// RULE_18: Under serial control source, mute, speed and format pins OR registers.
// RULE_19: Control mode pin low means serial control, high means pin control.
// RULE_20: Registers clear on power-down; writes only while power-down is high.
`timescale 1ns/1ps
`default_nettype none
module mcmc_top
  import mcmc_pkg::*;
#(
  parameter int ZERO_FRAMES = ZERO_FRAMES_DEF
) (
  // System
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  // Mode pins
  input  wire logic       i_output_source_select,
  input  wire logic       i_control_bus_select,
  input  wire logic       i_soft_mute_pin,
  input  wire logic       i_double_speed_select,
  input  wire logic       i_zero_detect_enable,
  input  wire logic       i_power_down_n,
  input  wire logic       i_control_mode_select,
  input  wire logic       i_frame_format_pin,
  input  wire logic       i_chip_address_bit0,
  input  wire logic       i_chip_address_bit1,
  // Control port
  input  wire logic       i_ctl_csn,
  input  wire logic       i_ctl_clk,
  input  wire logic       i_ctl_data_in,
  output logic            o_ctl_data_out,
  output logic            o_ctl_data_oe,
  // Audio link
  input  wire logic       i_bit_clk,
  input  wire logic       i_frame_clock,
  input  wire logic [3:0] i_serial_in,
  input  wire logic       i_conv_serial,
  input  wire logic       i_aux_serial_in,
  output logic            o_serial_audio_out,
  // Mode and status outputs
  output logic            o_control_port_i2c,
  output logic            o_double_speed,
  output logic            o_tdm_mode,
  output logic [1:0]      o_deemphasis_select,
  output logic            o_powered_down,
  output logic [7:0]      o_pair4_left_level,
  output logic [7:0]      o_pair4_right_level,
  output logic            o_first_zero_flag,
  output logic            o_second_zero_flag
);

  mcmc_pins_t pin_raw, pin_s1_r, pin_s2_r, pin_q_r;
  mcmc_regs_t regs_r;
  mcmc_i2c_t  i2c_st_r;
  logic       serial, eff_src, eff_soft_mute_pin, eff_dfs, eff_tdm;
  logic       eff_src_r, frame_tick, wr_en, tw_wr, i2c_wr;
  logic [4:0] wr_addr;
  logic [7:0] wr_data, zero_vec_r, zvec_r, mask1, mask2;
  logic [3:0] zero_mode_r;

  assign pin_raw = '{src: i_output_source_select,
                     bus_sel: i_control_bus_select,
                     soft_mute_pin: i_soft_mute_pin,
                     double_speed_select: i_double_speed_select,
                     zde: i_zero_detect_enable,
                     power_down_n: i_power_down_n,
                     cms: i_control_mode_select,
                     tdm: i_frame_format_pin,
                     cad: {i_chip_address_bit1, i_chip_address_bit0},
                     csn: i_ctl_csn, cclk: i_ctl_clk,
                     cdti: i_ctl_data_in, scl: i_ctl_clk,
                     sda: i_ctl_data_in};

  // Pin synchroniser plus one history stage for edges
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1_r <= PINS_RST;
      pin_s2_r <= PINS_RST;
      pin_q_r  <= PINS_RST;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_q_r  <= pin_s2_r;
    end
  end

  assign serial    = !pin_s2_r.cms;                            // RULE_19
  assign eff_src   = pin_s2_r.src   | (serial & regs_r.src);   // RULE_18
  assign eff_soft_mute_pin = pin_s2_r.soft_mute_pin | (serial & regs_r.soft_mute_pin); // RULE_18
  assign eff_dfs   = pin_s2_r.double_speed_select   | (serial & regs_r.double_speed_select);   // RULE_18
  assign eff_tdm   = pin_s2_r.tdm   | (serial & regs_r.tdm);   // RULE_18

  function automatic logic [7:0] rd_byte(input logic [4:0] a,
                                         input mcmc_regs_t r,
                                         input logic [1:0] z);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      ADDR_FRAME: begin
        d[FRM_TDM_BIT]  = r.tdm;
        d[FRM_SRC_BIT]  = r.src;
        d[FRM_DFS_BIT]  = r.double_speed_select;
        d[FRM_MUTE_BIT] = r.soft_mute_pin;
      end
      ADDR_DEEMPH: d[1:0] = r.deemph;
      ADDR_RAMP:   d[1:0] = r.ramp;
      ADDR_ZDET:   d[3:0] = r.zdm;
      ADDR_VOL4L:  d      = r.vol_l;
      ADDR_VOL4R:  d      = r.vol_r;
      ADDR_STATUS: d[1:0] = z;
      default:     d      = 8'h00;
    endcase
    return d;
  endfunction : rd_byte

  // Three-wire port: chip address, write flag, address, data
  logic [15:0] tw_sh_r;
  logic [4:0]  tw_cnt_r;
  logic        tw_act;
  assign tw_act = serial && !pin_s2_r.bus_sel;                 // RULE_03
  assign tw_wr  = tw_act && pin_s2_r.csn && !pin_q_r.csn
                  && tw_cnt_r == TW_LEN
                  && tw_sh_r[15:14] == pin_s2_r.cad && tw_sh_r[13];

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tw_sh_r  <= 16'h0000;
      tw_cnt_r <= 5'h00;
    end else if (!tw_act || pin_s2_r.csn) begin
      tw_cnt_r <= 5'h00;
    end else if (pin_s2_r.cclk && !pin_q_r.cclk) begin
      tw_sh_r  <= {tw_sh_r[14:0], pin_s2_r.cdti};
      if (tw_cnt_r != TW_LEN)
        tw_cnt_r <= tw_cnt_r + 5'h01;
    end
  end

  // I2C slave with auto increment
  logic       i2c_act, scl_rise, scl_fall, i2c_start, i2c_stop, i2c_rw_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] i2c_sh_r;
  logic [4:0] ptr_r;
  logic [7:0] rd_cur, rd_nxt;
  assign rd_cur = rd_byte(ptr_r, regs_r, zero_vec_r[1:0]);
  assign rd_nxt = rd_byte(ptr_r + 5'h01, regs_r, zero_vec_r[1:0]);
  assign i2c_act   = serial && pin_s2_r.bus_sel;               // RULE_03
  assign scl_rise  = pin_s2_r.scl && !pin_q_r.scl;
  assign scl_fall  = !pin_s2_r.scl && pin_q_r.scl;
  assign i2c_start = pin_s2_r.scl && pin_q_r.scl
                     && !pin_s2_r.sda && pin_q_r.sda;
  assign i2c_stop  = pin_s2_r.scl && pin_q_r.scl
                     && pin_s2_r.sda && !pin_q_r.sda;
  assign i2c_wr    = i2c_st_r == I2C_WDAT && scl_fall
                     && bit_cnt_r == BYTE_BITS;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      i2c_st_r      <= I2C_IDLE;
      bit_cnt_r     <= 4'h0;
      i2c_sh_r      <= 8'h00;
      ptr_r         <= 5'h00;
      i2c_rw_r      <= 1'b0;
      o_ctl_data_oe <= 1'b0;
    end else if (!i2c_act || !pin_s2_r.power_down_n || i2c_stop) begin
      i2c_st_r      <= I2C_IDLE;
      o_ctl_data_oe <= 1'b0;
    end else if (i2c_start) begin
      i2c_st_r      <= I2C_DEV;
      bit_cnt_r     <= 4'h0;
      o_ctl_data_oe <= 1'b0;
    end else if (scl_rise) begin
      if (i2c_st_r == I2C_ACK && i2c_rw_r && pin_s2_r.sda)
        i2c_st_r <= I2C_IDLE;
      else if (i2c_st_r == I2C_DEV || i2c_st_r == I2C_REG
               || i2c_st_r == I2C_WDAT) begin
        i2c_sh_r  <= {i2c_sh_r[6:0], pin_s2_r.sda};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end else if (scl_fall) begin
      case (i2c_st_r)
        I2C_DEV: if (bit_cnt_r == BYTE_BITS) begin
          if (i2c_sh_r[7:1] == {I2C_BASE, pin_s2_r.cad}) begin
            i2c_rw_r      <= i2c_sh_r[0];
            o_ctl_data_oe <= 1'b1;
            i2c_st_r      <= I2C_DACK;
          end else
            i2c_st_r <= I2C_IDLE;
        end
        I2C_DACK: begin
          bit_cnt_r <= 4'h0;
          if (i2c_rw_r) begin
            i2c_sh_r      <= rd_cur;
            o_ctl_data_oe <= !rd_cur[7];
            i2c_st_r      <= I2C_RDAT;
          end else begin
            o_ctl_data_oe <= 1'b0;
            i2c_st_r      <= I2C_REG;
          end
        end
        I2C_REG: if (bit_cnt_r == BYTE_BITS) begin
          ptr_r         <= i2c_sh_r[4:0];
          o_ctl_data_oe <= 1'b1;
          i2c_st_r      <= I2C_ACK;
        end
        I2C_WDAT: if (bit_cnt_r == BYTE_BITS) begin
          ptr_r         <= ptr_r + 5'h01;
          o_ctl_data_oe <= 1'b1;
          i2c_st_r      <= I2C_ACK;
        end
        I2C_ACK: begin
          bit_cnt_r <= 4'h0;
          if (i2c_rw_r) begin
            ptr_r         <= ptr_r + 5'h01;
            i2c_sh_r      <= rd_nxt;
            o_ctl_data_oe <= !rd_nxt[7];
            i2c_st_r      <= I2C_RDAT;
          end else begin
            o_ctl_data_oe <= 1'b0;
            i2c_st_r      <= I2C_WDAT;
          end
        end
        I2C_RDAT: if (bit_cnt_r == 4'h7) begin
          o_ctl_data_oe <= 1'b0;
          i2c_st_r      <= I2C_ACK;
        end else begin
          i2c_sh_r      <= {i2c_sh_r[6:0], 1'b0};
          o_ctl_data_oe <= !i2c_sh_r[6];
          bit_cnt_r     <= bit_cnt_r + 4'h1;
        end
        I2C_IDLE: i2c_st_r <= I2C_IDLE;
        default:  i2c_st_r <= I2C_IDLE;
      endcase
    end
  end

  // Open drain: the pin only ever pulls low
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b)
      o_ctl_data_out <= 1'b0;
    else
      o_ctl_data_out <= 1'b0;
  end

  assign wr_en   = pin_s2_r.power_down_n && (tw_wr || i2c_wr);          // RULE_20
  assign wr_addr = tw_wr ? tw_sh_r[12:8] : ptr_r;
  assign wr_data = tw_wr ? tw_sh_r[7:0] : i2c_sh_r;

  // Register file
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      regs_r <= REGS_RST;
    end else if (!pin_s2_r.power_down_n) begin
      regs_r <= REGS_RST;                                      // RULE_08
    end else if (wr_en) begin
      case (wr_addr)
        ADDR_FRAME: begin
          regs_r.tdm   <= wr_data[FRM_TDM_BIT];                // RULE_13
          regs_r.src   <= wr_data[FRM_SRC_BIT];
          regs_r.double_speed_select   <= wr_data[FRM_DFS_BIT];
          regs_r.soft_mute_pin <= wr_data[FRM_MUTE_BIT];
        end
        ADDR_DEEMPH: regs_r.deemph <= wr_data[1:0];            // RULE_14
        ADDR_RAMP:   regs_r.ramp   <= wr_data[1:0];            // RULE_10
        ADDR_ZDET:   regs_r.zdm    <= wr_data[3:0];            // RULE_15
        ADDR_VOL4L:  regs_r.vol_l  <= wr_data;                 // RULE_11
        ADDR_VOL4R:  regs_r.vol_r  <= wr_data;                 // RULE_11
        default:     regs_r        <= regs_r;
      endcase
    end
  end

  // Mode outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      eff_src_r           <= 1'b0;
      o_control_port_i2c  <= 1'b0;
      o_double_speed      <= 1'b0;
      o_tdm_mode          <= 1'b0;
      o_deemphasis_select <= 2'h0;
      o_powered_down      <= 1'b1;
      zero_mode_r         <= ZDM_OFF;
    end else begin
      eff_src_r           <= eff_src;                          // RULE_01
      o_control_port_i2c  <= pin_s2_r.bus_sel;                 // RULE_03
      o_double_speed      <= eff_dfs;                          // RULE_05
      o_tdm_mode          <= eff_tdm;
      o_deemphasis_select <= serial ? regs_r.deemph : 2'h0;
      o_powered_down      <= !pin_s2_r.power_down_n;                    // RULE_08
      if (pin_s2_r.zde)
        zero_mode_r <= ZDM_ALL;                                // RULE_07
      else
        zero_mode_r <= serial ? regs_r.zdm : ZDM_OFF;          // RULE_06
    end
  end

  // Link domain: zero gathering per channel and output mux
  logic       fc_q_r, tgl_r, src_s1_r, src_s2_r;
  logic [3:0] acc_r, zl_r;
  always_ff @(posedge i_bit_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fc_q_r <= 1'b0;
      tgl_r  <= 1'b0;
      acc_r  <= 4'h0;
      zl_r   <= 4'h0;
      zvec_r <= 8'h00;
    end else begin
      fc_q_r <= i_frame_clock;
      if (i_frame_clock != fc_q_r) begin
        acc_r <= i_serial_in;
        if (fc_q_r)
          zl_r <= ~acc_r;
        else begin
          zvec_r <= {~acc_r, zl_r};
          tgl_r  <= !tgl_r;
        end
      end else
        acc_r <= acc_r | i_serial_in;
    end
  end

  always_ff @(posedge i_bit_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      src_s1_r           <= 1'b0;
      src_s2_r           <= 1'b0;
      o_serial_audio_out <= 1'b0;
    end else begin
      src_s1_r           <= eff_src_r;
      src_s2_r           <= src_s1_r;
      o_serial_audio_out <= src_s2_r ? i_aux_serial_in
                                     : i_conv_serial;          // RULE_01
    end
  end

  // Frame toggle crossing; vector is stable for a whole frame
  logic tg_s1_r, tg_s2_r, tg_q_r;
  assign frame_tick = tg_s2_r ^ tg_q_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tg_s1_r    <= 1'b0;
      tg_s2_r    <= 1'b0;
      tg_q_r     <= 1'b0;
      zero_vec_r <= 8'h00;
    end else begin
      tg_s1_r <= tgl_r;
      tg_s2_r <= tg_s1_r;
      tg_q_r  <= tg_s2_r;
      if (frame_tick)
        zero_vec_r <= zvec_r;
    end
  end

  // Volume ramp, one level per step
  logic [4:0] pres_r, step_lim;
  logic [7:0] tgt_l, tgt_r;
  always_comb begin
    case (serial ? regs_r.ramp : RAMP_SLOW)
      RAMP_SLOW: step_lim = STEP_SLOW;                         // RULE_10
      RAMP_MID:  step_lim = STEP_MID;
      default:   step_lim = STEP_FAST;
    endcase
    tgt_l = eff_soft_mute_pin ? VOL_MUTE : (serial ? regs_r.vol_l : VOL_FULL);
    tgt_r = eff_soft_mute_pin ? VOL_MUTE : (serial ? regs_r.vol_r : VOL_FULL);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pres_r              <= 5'h00;
      o_pair4_left_level  <= VOL_MUTE;
      o_pair4_right_level <= VOL_MUTE;
    end else if (!pin_s2_r.power_down_n) begin
      pres_r              <= 5'h00;
      o_pair4_left_level  <= VOL_MUTE;
      o_pair4_right_level <= VOL_MUTE;
    end else if (frame_tick) begin
      if (pres_r >= step_lim - 5'h01) begin
        pres_r <= 5'h00;
        if (o_pair4_left_level < tgt_l)                        // RULE_12
          o_pair4_left_level <= o_pair4_left_level + 8'h01;
        else if (o_pair4_left_level > tgt_l)                   // RULE_04
          o_pair4_left_level <= o_pair4_left_level - 8'h01;
        if (o_pair4_right_level < tgt_r)
          o_pair4_right_level <= o_pair4_right_level + 8'h01;
        else if (o_pair4_right_level > tgt_r)
          o_pair4_right_level <= o_pair4_right_level - 8'h01;
      end else
        pres_r <= pres_r + 5'h01;
    end
  end

  // Zero flags from consecutive all-zero frames
  logic [13:0] zc1_r, zc2_r;
  always_comb begin
    case (zero_mode_r)
      ZDM_ALL: begin
        mask1 = MASK_ALL;
        mask2 = MASK_NONE;
      end
      ZDM_OFF: begin
        mask1 = MASK_NONE;
        mask2 = MASK_NONE;
      end
      default: begin
        mask1 = MASK_LO;
        mask2 = MASK_HI;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      zc1_r              <= 14'h0000;
      zc2_r              <= 14'h0000;
      o_first_zero_flag  <= 1'b0;
      o_second_zero_flag <= 1'b0;
    end else if (!pin_s2_r.power_down_n) begin
      zc1_r              <= 14'h0000;
      zc2_r              <= 14'h0000;
      o_first_zero_flag  <= 1'b0;
      o_second_zero_flag <= 1'b0;
    end else begin
      if (mask1 == MASK_NONE || (zero_vec_r & mask1) != mask1)
        zc1_r <= 14'h0000;                                     // RULE_07
      else if (frame_tick && zc1_r != 14'(ZERO_FRAMES))
        zc1_r <= zc1_r + 14'h0001;
      if (mask2 == MASK_NONE || (zero_vec_r & mask2) != mask2)
        zc2_r <= 14'h0000;
      else if (frame_tick && zc2_r != 14'(ZERO_FRAMES))
        zc2_r <= zc2_r + 14'h0001;
      o_first_zero_flag  <= zc1_r == 14'(ZERO_FRAMES);         // RULE_17
      o_second_zero_flag <= zc2_r == 14'(ZERO_FRAMES);         // RULE_17
    end
  end

  property p_src_mux;
    @(posedge i_bit_clk) disable iff (!i_rst_b)
      $past(i_rst_b) |-> o_serial_audio_out == $past(src_s2_r ? i_aux_serial_in
                                           : i_conv_serial);
  endproperty
  a_src_mux: assert property (p_src_mux) else $error("bad out source"); // RULE_01

  property p_no_tw_in_i2c;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      pin_s2_r.bus_sel |-> !tw_wr;
  endproperty
  a_no_tw_in_i2c: assert property (p_no_tw_in_i2c) else $error("tw write"); // RULE_03

  property p_mute_falls;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (eff_soft_mute_pin && $past(eff_soft_mute_pin))
        |-> o_pair4_left_level <= $past(o_pair4_left_level);
  endproperty
  a_mute_falls: assert property (p_mute_falls) else $error("mute rise"); // RULE_04

  property p_dfs;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      pin_s2_r.double_speed_select |=> o_double_speed;
  endproperty
  a_dfs: assert property (p_dfs) else $error("speed not double"); // RULE_05

  property p_zde_high;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      pin_s2_r.zde |=> (mask1 == MASK_ALL && mask2 == MASK_NONE);
  endproperty
  a_zde_high: assert property (p_zde_high) else $error("mode not 0"); // RULE_07

  property p_pdn_clear;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      !pin_s2_r.power_down_n |=> (regs_r == REGS_RST && o_powered_down);
  endproperty
  a_pdn_clear: assert property (p_pdn_clear) else $error("no clear"); // RULE_08

  property p_zero_count;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      $rose(o_first_zero_flag) |-> $past(zc1_r) == 14'(ZERO_FRAMES);
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("early flag"); // RULE_17

  property p_tdm_or;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (serial && regs_r.tdm) |=> o_tdm_mode;
  endproperty
  a_tdm_or: assert property (p_tdm_or) else $error("tdm not ored"); // RULE_18

  property p_no_wr_down;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      !pin_s2_r.power_down_n |-> !wr_en;
  endproperty
  a_no_wr_down: assert property (p_no_wr_down) else $error("write in pd"); // RULE_20

  property p_ramp_step;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (serial && regs_r.ramp == RAMP_MID) |-> step_lim == STEP_MID;
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("bad ramp"); // RULE_10

endmodule : mcmc_top
`default_nettype wire

// file: test/mcmc_audio_src.sv
// Purpose: Far-side audio source feeding the codec link
// Assumes: Bit clock comes from the bench
// Notes:   Eight bit clocks per half frame
`timescale 1ns/1ps
`default_nettype none
module mcmc_audio_src (
  // Link
  input  wire logic       i_bit_clk,
  input  wire logic       i_quiet,
  output logic            o_frame_clock,
  output logic [3:0]      o_serial_in,
  output logic            o_conv_serial,
  output logic            o_aux_serial_in
);
  logic [3:0] cnt_r = 4'h0;
  // Change on the falling edge, away from the sampling edge
  always_ff @(negedge i_bit_clk) cnt_r <= cnt_r + 4'h1;
  assign o_frame_clock   = cnt_r[3];
  assign o_serial_in     = i_quiet ? 4'h0 : {4{cnt_r[0]}};
  assign o_conv_serial   = 1'b1;
  assign o_aux_serial_in = 1'b0;
endmodule : mcmc_audio_src
`default_nettype wire

// file: test/multichannel_codec_mode_control_test.sv
// Purpose: Self-checking bench for the codec mode and control block
// Assumes: Serial control mode except one pin control check in t_power, both control port types
// Notes:   Zero detect count shortened to 16 frames
`timescale 1ns/1ps
`default_nettype none
module multichannel_codec_mode_control_test;
  import mcmc_pkg::*;
  logic clk = 0, bclk = 0, rst_b = 0, power_down_n = 1, src = 0, bsel = 0;
  logic soft_mute_pin = 0, double_speed_select = 0, zde = 0, csn = 1, cclk = 1, cdi = 0;
  logic quiet = 0, cms = 0;
  logic [1:0] cad = 2'h2;
  logic fc, conv, aux, sout, i2c, dsp, tdm, pd, z1, z2, dout, doe;
  logic [3:0] sin;
  logic [1:0] dem;
  logic [7:0] lvl, rvl;
  int fails = 0, check_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  // Offset keeps link edges off the system clock edges
  initial begin
    #3.1;
    forever #7.5 bclk = ~bclk;
  end
  mcmc_audio_src u_src (.i_bit_clk(bclk), .i_quiet(quiet),
    .o_frame_clock(fc), .o_serial_in(sin), .o_conv_serial(conv),
    .o_aux_serial_in(aux));
  mcmc_top #(.ZERO_FRAMES(16)) u_dut (.i_clk_sys(clk), .i_rst_b(rst_b),
    .i_output_source_select(src), .i_control_bus_select(bsel),
    .i_soft_mute_pin(soft_mute_pin), .i_double_speed_select(double_speed_select),
    .i_zero_detect_enable(zde), .i_power_down_n(power_down_n),
    .i_control_mode_select(cms), .i_frame_format_pin(1'b0),
    .i_chip_address_bit0(cad[0]), .i_chip_address_bit1(cad[1]),
    .i_ctl_csn(csn), .i_ctl_clk(cclk), .i_ctl_data_in(cdi),
    .o_ctl_data_out(dout), .o_ctl_data_oe(doe), .i_bit_clk(bclk),
    .i_frame_clock(fc), .i_serial_in(sin), .i_conv_serial(conv),
    .i_aux_serial_in(aux), .o_serial_audio_out(sout),
    .o_control_port_i2c(i2c), .o_double_speed(dsp), .o_tdm_mode(tdm),
    .o_deemphasis_select(dem), .o_powered_down(pd),
    .o_pair4_left_level(lvl), .o_pair4_right_level(rvl),
    .o_first_zero_flag(z1), .o_second_zero_flag(z2));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic waitc(input int n);
    repeat (n) @(negedge clk);
  endtask : waitc
  task automatic tw_write(input logic [4:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {cad, 1'b1, a, d};
    csn = 0;
    waitc(4);
    for (int i = 15; i >= 0; i--) begin
      cclk = 0;
      cdi = f[i];
      waitc(4);
      cclk = 1;
      waitc(4);
    end
    csn = 1;
    waitc(8);
  endtask : tw_write
  task automatic t_modes;
    src = 1;
    waitc(8);
    chk(sout, 1'b0);
    src = 0;
    double_speed_select = 1;
    waitc(8);
    chk(sout, 1'b1);
    chk(dsp, 1'b1);
    double_speed_select = 0;
    tw_write(ADDR_FRAME, 8'hA0);
    chk(tdm, 1'b1);
    chk(dsp, 1'b1);
    bsel = 1;
    waitc(8);
    chk(i2c, 1'b1);
    bsel = 0;
    tw_write(ADDR_DEEMPH, 8'h03);
    chk(dem, 2'h3);
  endtask : t_modes
  task automatic i2c_bit(input logic b);
    cdi = b;
    waitc(4);
    cclk = 1;
    waitc(4);
    cclk = 0;
  endtask : i2c_bit
  task automatic t_i2c;
    logic [26:0] f;
    f = {I2C_BASE, cad, 1'b0, 1'b1, 3'h0, ADDR_DEEMPH, 1'b1, 8'h01, 1'b1};
    bsel = 1;
    cdi = 1;
    waitc(8);
    cdi = 0;
    waitc(4);
    cclk = 0;
    for (int i = 26; i >= 0; i--) begin
      i2c_bit(f[i]);
      if (i == 18) chk(doe, 1'b1);
    end
    cdi = 0;
    waitc(4);
    cclk = 1;
    waitc(4);
    cdi = 1;
    waitc(4);
    bsel = 0;
    waitc(8);
    chk(dem, 2'h1);
    chk(dout, 1'b0);
  endtask : t_i2c
  task automatic t_volume;
    tw_write(ADDR_RAMP, {6'h00, RAMP_MID});
    tw_write(ADDR_VOL4L, 8'h05);
    tw_write(ADDR_VOL4R, 8'h02);
    chk(lvl < 8'h05, 1'b1);
    waitc(300);
    chk(lvl, 8'h05);
    chk(rvl, 8'h02);
    soft_mute_pin = 1;
    waitc(300);
    chk(lvl, 8'h00);
    soft_mute_pin = 0;
    waitc(300);
    chk(lvl, 8'h05);
  endtask : t_volume
  task automatic t_zero;
    zde = 1;
    quiet = 1;
    waitc(60);
    chk(z1, 1'b0);
    waitc(200);
    chk(z1, 1'b1);
    chk(z2, 1'b0);
    quiet = 0;
    waitc(40);
    chk(z1, 1'b0);
    zde = 0;
  endtask : t_zero
  task automatic t_power;
    cms = 1;
    waitc(6);
    chk(dem, 2'h0);
    power_down_n = 0;
    cms = 0;
    waitc(6);
    chk(pd, 1'b1);
    chk(tdm, 1'b0);
    tw_write(ADDR_DEEMPH, 8'h02);
    power_down_n = 1;
    waitc(6);
    chk(dem, 2'h0);
    chk(pd, 1'b0);
  endtask : t_power
  task automatic complete_run;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    waitc(11);
    chk(pd, 1'b1);
    chk(lvl, 8'h00);
    waitc(1);
    rst_b = 1;
    waitc(6);
    t_modes();
    t_i2c();
    t_volume();
    t_zero();
    t_power();
    complete_run();
  end
endmodule : multichannel_codec_mode_control_test
`default_nettype wire
